// [hdl/edge_events.sv]
// rise and fall pulse detector for a vector of same-clock levels
// assumes every level is already synchronous to pclk
`timescale 1ns/1ps
module edge_events
#(
  parameter int WIDTH = 5
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] prev_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prev_q <= '0;
    else
      prev_q <= level;
  end

  for (genvar i = 0; i < WIDTH; i++)
  begin : g_edge
    assign rise[i] = level[i] & ~prev_q[i];
    assign fall[i] = ~level[i] & prev_q[i];
  end
endmodule // edge_events

// [hdl/pin_sync.sv]
// two-flop synchroniser for levels arriving from pins
// assumes the inputs are quasi-static levels, not pulses
`timescale 1ns/1ps
module pin_sync
#(
  parameter int WIDTH = 1
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // pin_sync

// [hdl/radio_coex_status_irq.sv]
// radio arbiter decision, status view and event interrupt, as an apb slave
// assumes a same-clock slot resolver offering the winning mac and slot index
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`include "arb_map.svh"
module radio_coex_status_irq
#(
  parameter int ADDR_W = 12,
  parameter int SLOT_W = 5
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_activity_in0,
  input wire logic ble_active_in,
  input wire logic ble_txrx_en_in,
  input wire logic ext_txrx_en_in,
  input wire logic radio_busy_in,
  input wire logic slot_req_valid,
  input wire logic [1:0] slot_req_mac,
  input wire logic [SLOT_W-1:0] slot_req_index,
  output logic onchip_priority_out,
  output logic onchip_active_out,
  output logic irq
);
  // ************************************************
  // declarations
  // ************************************************
  localparam int E_ACT = 0;
  localparam int E_PRI = 1;
  localparam int E_EXT = 2;
  localparam int E_BLE = 3;
  localparam int E_BUSY = 4;
  localparam int E_W = 5;

  arb_pkg::arb_state_type state_q, state_d;
  arb_pkg::decision_type decision_q, decision_d, last_owner_q, req_mac;
  logic [SLOT_W-1:0] slot_q, slot_d;
  logic accept, enter_closing;
  logic prog_q, radio_busy_q, ext_s;
  logic [`REG_W-1:0] mask_q, evst_q, evst_d, ev_set, ev_clr;
  logic summary_d;
  logic [E_W-1:0] lv, lv_rise, lv_fall;
  logic setup, access, hit, rd_events_q, rd_status_q;
  logic [31:0] rdata_d;

  function automatic logic mac_active(arb_pkg::decision_type d, logic ble, logic ext);
    mac_active = (d == arb_pkg::dec_ble) ? ble : ((d == arb_pkg::dec_ext) ? ext : 1'b0);
  endfunction

  function automatic logic reg_hit(logic [ADDR_W-1:0] a, logic [31:0] idx);
    reg_hit = (a[`IDX_LSB +: `IDX_W] == idx[`IDX_W-1:0]);
  endfunction

  // ************************************************
  // input capture
  // ************************************************
  pin_sync #(
    .WIDTH(1)
  ) u_ext_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(external_activity_in0),
    .sync_out(ext_s)
  );

  // the busy level is used one cycle late, while ble_active_in is used as it arrives
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      radio_busy_q <= 1'b0;
    else
      radio_busy_q <= radio_busy_in;
  end

  // ************************************************
  // decision state machine
  // ************************************************
  assign req_mac = arb_pkg::decision_type'(slot_req_mac);

  always_comb
  begin
    state_d = state_q;
    decision_d = decision_q;
    slot_d = slot_q;
    accept = 1'b0;
    enter_closing = 1'b0;
    unique case (state_q)
      arb_pkg::arb_idle:
      begin
        // a requester that is not active cannot be granted
        if (!prog_q && slot_req_valid && mac_active(req_mac, ble_active_in, ext_s))
        begin
          accept = 1'b1;
          state_d = arb_pkg::arb_owned;
          decision_d = req_mac;
          slot_d = slot_req_index;
        end
      end
      arb_pkg::arb_owned:
      begin
        if (!mac_active(decision_q, ble_active_in, ext_s))
        begin
          enter_closing = 1'b1;
          state_d = arb_pkg::arb_closing;
        end
      end
      arb_pkg::arb_closing:
      begin
        // the running transaction always completes, even in programming mode
        if (!radio_busy_q)
        begin
          state_d = arb_pkg::arb_idle;
          decision_d = arb_pkg::dec_none;
        end
      end
      default:
      begin
        state_d = arb_pkg::arb_idle;
        decision_d = arb_pkg::dec_none;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= arb_pkg::arb_idle;
      decision_q <= arb_pkg::dec_none;
      slot_q <= '0;
      last_owner_q <= arb_pkg::dec_none;
    end
    else
    begin
      state_q <= state_d;
      decision_q <= decision_d;
      slot_q <= slot_d;
      if (accept)
        last_owner_q <= req_mac;
    end
  end

  // priority follows the next decision so it is never high under none
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      onchip_priority_out <= 1'b0;
      onchip_active_out <= 1'b0;
    end
    else
    begin
      onchip_priority_out <= (decision_d == arb_pkg::dec_ble);
      onchip_active_out <= ble_active_in;
    end
  end

  // ************************************************
  // events
  // ************************************************
  assign lv = {radio_busy_q, ble_active_in, ext_s, onchip_priority_out, onchip_active_out};

  edge_events #(
    .WIDTH(E_W)
  ) u_edges (
    .pclk(pclk),
    .presetn(presetn),
    .level(lv),
    .rise(lv_rise),
    .fall(lv_fall)
  );

  always_comb
  begin
    ev_set = `REG_RST;
    // passes through none are invisible: compare with the last real owner
    ev_set[`EV_SWITCH] = accept && (req_mac != last_owner_q);
    ev_set[`EV_MID] = accept && (req_mac == arb_pkg::dec_ble ? ble_txrx_en_in : ext_txrx_en_in);
    ev_set[`EV_BREAK] = enter_closing
      && (decision_q == arb_pkg::dec_ble ? ble_txrx_en_in : ext_txrx_en_in);
    ev_set[`EV_BUSY_F] = lv_fall[E_BUSY];
    ev_set[`EV_BUSY_R] = lv_rise[E_BUSY];
    ev_set[`EV_BLE_F] = lv_fall[E_BLE];
    ev_set[`EV_BLE_R] = lv_rise[E_BLE];
    ev_set[`EV_EXT_F] = lv_fall[E_EXT];
    ev_set[`EV_EXT_R] = lv_rise[E_EXT];
    ev_set[`EV_PRI_F] = lv_fall[E_PRI];
    ev_set[`EV_PRI_R] = lv_rise[E_PRI];
    ev_set[`EV_ACT_F] = lv_fall[E_ACT];
    ev_set[`EV_ACT_R] = lv_rise[E_ACT];
  end

  // a read clears only the bits it returned, so a same-cycle set survives
  assign ev_clr = ((access && rd_events_q) ? prdata[`REG_W-1:0] : `REG_RST)
    | ((access && pwrite && reg_hit(paddr, `IDX_EVENTS)) ? pwdata[`REG_W-1:0] : `REG_RST);
  assign evst_d = ((evst_q & ~ev_clr) | ev_set) & `EV_IMPL;
  assign summary_d = |(evst_d & mask_q & `EV_IMPL);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      evst_q <= `REG_RST;
      irq <= 1'b0;
    end
    else
    begin
      evst_q <= evst_d;
      irq <= summary_d && mask_q[`MASK_GIE];
    end
  end

  // ************************************************
  // apb slave
  // ************************************************
  assign setup = psel && !penable;
  assign access = psel && penable && pready;

  always_comb
  begin
    rdata_d = 32'h0000_0000;
    hit = 1'b1;
    if (reg_hit(paddr, `IDX_CONTROL))
      rdata_d[`CTRL_PROG] = prog_q;
    else if (reg_hit(paddr, `IDX_STATUS))
    begin
      rdata_d[`ST_EXT0] = ext_s;
      rdata_d[`ST_PRI] = onchip_priority_out;
      rdata_d[`ST_ACT] = onchip_active_out;
      rdata_d[`ST_CLOSING] = (state_q == arb_pkg::arb_closing);
      rdata_d[`ST_DEC_LO +: 2] = decision_q;
      rdata_d[`ST_SLOT_LO +: SLOT_W] = slot_q;
    end
    else if (reg_hit(paddr, `IDX_MASK))
      rdata_d[`REG_W-1:0] = mask_q;
    else if (reg_hit(paddr, `IDX_EVENTS))
    begin
      rdata_d[`REG_W-1:0] = evst_q;
      rdata_d[`EV_SUMMARY] = |(evst_q & mask_q & `EV_IMPL);
    end
    else
      hit = 1'b0;
  end

  // one wait-free answer: data is captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      rd_events_q <= 1'b0;
      rd_status_q <= 1'b0;
    end
    else
    begin
      pready <= setup;
      if (setup)
      begin
        prdata <= pwrite ? 32'h0000_0000 : rdata_d;
        pslverr <= !hit;
        rd_events_q <= !pwrite && reg_hit(paddr, `IDX_EVENTS);
        rd_status_q <= !pwrite && reg_hit(paddr, `IDX_STATUS);
      end
      else if (access)
      begin
        rd_events_q <= 1'b0;
        rd_status_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prog_q <= 1'b0;
      mask_q <= `REG_RST;
    end
    else if (access && pwrite)
    begin
      if (reg_hit(paddr, `IDX_CONTROL))
        prog_q <= pwdata[`CTRL_PROG];
      if (reg_hit(paddr, `IDX_MASK))
        mask_q <= pwdata[`REG_W-1:0] & `MASK_IMPL;
    end
  end

  // ************************************************
  // assertions
  // ************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_live_pins: assert property (
    pready && rd_status_q |-> prdata[`ST_EXT0] == $past(ext_s)
      && prdata[`ST_PRI] == $past(onchip_priority_out)
      && prdata[`ST_ACT] == $past(onchip_active_out))
    else $error("status pin bits do not match live levels");

  a_closing_read: assert property (
    pready && rd_status_q |-> prdata[`ST_CLOSING] == $past(state_q == arb_pkg::arb_closing))
    else $error("closing flag wrong in status read");

  a_result_code: assert property (
    decision_q != arb_pkg::dec_rsvd
      && ((state_q == arb_pkg::arb_idle) == (decision_q == arb_pkg::dec_none)))
    else $error("decision code inconsistent with state");

  a_priority_low: assert property (
    decision_q == arb_pkg::dec_none |-> !onchip_priority_out)
    else $error("priority high while decision none");

  a_none_quiet: assert property (
    decision_q == arb_pkg::dec_none && !ble_active_in && !ext_s
      |=> decision_q == arb_pkg::dec_none)
    else $error("decision taken without activity");

  a_finish_none: assert property (
    state_q == arb_pkg::arb_closing && !radio_busy_q |=> decision_q == arb_pkg::dec_none)
    else $error("finished transaction did not return to none");

  a_prog_freeze: assert property (
    prog_q && decision_q == arb_pkg::dec_none |=> decision_q == arb_pkg::dec_none)
    else $error("new decision during programming");

  a_slot_stable: assert property (
    state_q != arb_pkg::arb_idle ##1 state_q != arb_pkg::arb_idle |-> $stable(slot_q))
    else $error("slot index moved while owned");

  a_mask_summary: assert property (
    irq |-> (|(evst_q & $past(mask_q) & `EV_IMPL)))
    else $error("interrupt without a masked event");

  a_edge_latch: assert property (
    lv_rise[E_EXT] |=> evst_q[`EV_EXT_R])
    else $error("external rise not latched");

  a_irq_gate: assert property (
    irq == ((|(evst_q & $past(mask_q) & `EV_IMPL)) && $past(mask_q[`MASK_GIE])))
    else $error("interrupt not gated by enable and summary");

  a_read_clear: assert property (
    access && rd_events_q && prdata[`EV_SWITCH] && !ev_set[`EV_SWITCH]
      |=> !evst_q[`EV_SWITCH])
    else $error("event not cleared by read");

  a_start_mid: assert property (
    accept && ev_set[`EV_MID] |=> evst_q[`EV_MID] ##1 state_q != arb_pkg::arb_idle)
    else $error("start during transfer not latched");

  a_reserved_zero: assert property (
    pready && rd_status_q |-> prdata[31:`ST_EXT0+1] == '0)
    else $error("reserved status bits not zero");

  c_owner_switch: cover property (ev_set[`EV_SWITCH] ##[1:50] ev_set[`EV_SWITCH]);
  c_closing: cover property (state_q == arb_pkg::arb_closing ##1 state_q == arb_pkg::arb_idle);
  c_irq_rise: cover property (!irq ##1 irq);
  c_prog_block: cover property (prog_q && slot_req_valid && state_q == arb_pkg::arb_idle);
endmodule // radio_coex_status_irq

// [pkg/arb_map.svh]
// register indices, field positions and reset values of the radio arbiter status block
// assumes the includer decodes word addresses from the register indices below
`ifndef ARB_MAP_SVH
`define ARB_MAP_SVH

// register indices; byte address is four times the index
`define IDX_CONTROL 32'h50002f00
`define IDX_STATUS 32'h50002f02
`define IDX_MASK 32'h50002f04
`define IDX_EVENTS 32'h50002f06
`define IDX_LSB 2
`define IDX_W 10
`define REG_W 16

// control
`define CTRL_PROG 0

// status
`define ST_EXT0 10
`define ST_PRI 9
`define ST_ACT 8
`define ST_CLOSING 7
`define ST_DEC_LO 5
`define ST_SLOT_LO 0

// event status and mask share one layout except bit 0: summary in event status, global enable in mask
`define EV_SWITCH 15
`define EV_MID 14
`define EV_BREAK 13
`define EV_BUSY_F 12
`define EV_BUSY_R 11
`define EV_BLE_F 10
`define EV_BLE_R 9
`define EV_EXT_F 6
`define EV_EXT_R 5
`define EV_PRI_F 4
`define EV_PRI_R 3
`define EV_ACT_F 2
`define EV_ACT_R 1
`define EV_SUMMARY 0
`define MASK_GIE 0
`define EV_IMPL 16'hfe7e
`define MASK_IMPL 16'hfe7f
`define REG_RST 16'h0000

`endif

// [pkg/arb_pkg.sv]
// types of the radio arbiter status block
// assumes nothing of its surroundings
package arb_pkg;
  typedef enum logic [1:0] {
    dec_none = 2'b00,
    dec_ble = 2'b01,
    dec_rsvd = 2'b10,
    dec_ext = 2'b11
  } decision_type;

  typedef enum logic [1:0] {
    arb_idle = 2'b00,
    arb_owned = 2'b01,
    arb_closing = 2'b10
  } arb_state_type;
endpackage

// [testbench/mac_pair_model.sv]
// far side model: on-chip mac and external mac activity, tx/rx enables and radio busy
// assumes the bench raises one request level per mac and picks prompt or slow timing
`timescale 1ns/1ps
module mac_pair_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] req,
  input wire logic slow,
  output logic [1:0] active,
  output logic [1:0] txrx,
  output logic busy
);
  logic [3:0] up_q [2];
  logic [3:0] tail_q [2];
  logic [3:0] lat;

  // a slow mac raises its enable late, so a grant can land before its transfer starts
  assign lat = slow ? 4'h6 : 4'h1;
  assign active = req;
  assign txrx[0] = req[0] ? (up_q[0] >= lat) : (tail_q[0] != 4'h0);
  assign txrx[1] = req[1] ? (up_q[1] >= lat) : (tail_q[1] != 4'h0);

  // the enable outlives the activity request, as a transfer winds down
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      up_q <= '{4'h0, 4'h0};
      tail_q <= '{4'h0, 4'h0};
      busy <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (req[i])
        begin
          up_q[i] <= (up_q[i] == 4'hf) ? up_q[i] : up_q[i] + 4'h1;
          tail_q[i] <= txrx[i] ? 4'h8 : 4'h0;
        end
        else
        begin
          up_q[i] <= 4'h0;
          tail_q[i] <= (tail_q[i] == 4'h0) ? 4'h0 : tail_q[i] - 4'h1;
        end
      end
      busy <= |txrx;
    end
  end
endmodule // mac_pair_model

// [testbench/radio_coex_status_irq_test.sv]
// self-checking bench of the arbiter status and interrupt block
// assumes the design's register map header and a mac pair model at the far side
`timescale 1ns/1ps
`include "arb_map.svh"
module radio_coex_status_irq_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [1:0] req, act, txrx, mac;
  logic [15:0] m;
  logic slow, busy, valid, pri, oact, irq, sirq, e;
  logic [4:0] idx;
  int n_mismatch, tests_run, cycles;

  radio_coex_status_irq #(.ADDR_W(12), .SLOT_W(5)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_activity_in0(act[1]), .ble_active_in(act[0]), .ble_txrx_en_in(txrx[0]),
    .ext_txrx_en_in(txrx[1]), .radio_busy_in(busy), .slot_req_valid(valid),
    .slot_req_mac(mac), .slot_req_index(idx), .onchip_priority_out(pri),
    .onchip_active_out(oact), .irq(irq));

  mac_pair_model macs (.pclk(pclk), .presetn(presetn), .req(req), .slow(slow),
    .active(act), .txrx(txrx), .busy(busy));

  // ****************
  // helpers
  // ****************
  function automatic logic [11:0] adr(input logic [31:0] index);
    return 12'(index << 2);
  endfunction

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  function automatic logic [31:0] exp_st(input logic x, p, a, c, input logic [1:0] d,
                                         input logic [4:0] s);
    return {21'h0, x, p, a, c, d, s};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // holds the request until pready is sampled high; bounded by the run timeout
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic offer(input logic [1:0] mc, input logic [4:0] ix);
    @(posedge pclk);
    valid <= 1'b1;
    mac <= mc;
    idx <= ix;
    @(posedge pclk);
    valid <= 1'b0;
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ****************
  // clock and timeout
  // ****************
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      n_mismatch++;
      give_verdict;
    end
  end

  // ****************
  // scenarios
  // ****************
  initial
  begin
    {presetn, psel, penable, pwrite, valid, slow} = 6'h00;
    {paddr, pwdata, req, mac, idx} = '0;
    seed = 32'h00013e51;
    tick(2);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, adr(`IDX_CONTROL + 32'(2 * i)), 32'h0);
      check(rd, 32'h0);
    end
    apb(1'b0, 12'hc04, 32'h0);
    check(32'(err), 32'h1);
    seed = xs(seed);
    apb(1'b1, adr(`IDX_MASK), seed);
    apb(1'b0, adr(`IDX_MASK), 32'h0);
    check(rd, {16'h0, seed[15:0] & `MASK_IMPL});
    apb(1'b1, adr(`IDX_MASK), 32'h0);
    apb(1'b1, adr(`IDX_STATUS), 32'hffff);
    offer(2'd1, 5'h3);
    apb(1'b0, adr(`IDX_STATUS), 32'h0);
    check(rd, 32'h0);
    check(32'(pri), 32'h0);
    // on-chip mac wins while its transfer already runs
    req[0] <= 1'b1;
    tick(4);
    // reserved and none codes must be refused even with an active mac
    offer(2'd2, 5'h7);
    offer(2'd0, 5'h9);
    offer(2'd1, seed[20:16] | 5'h1);
    tick(2);
    apb(1'b0, adr(`IDX_STATUS), 32'h0);
    check(rd, exp_st(0, 1, 1, 0, 2'd1, seed[20:16] | 5'h1));
    apb(1'b0, adr(`IDX_EVENTS), 32'h0);
    check({29'h0, rd[15:13]}, 32'h6);
    check(32'(rd[9]), 32'h1);
    apb(1'b0, adr(`IDX_EVENTS), 32'h0);
    check({30'h0, rd[15:14]}, 32'h0);
    req[0] <= 1'b0;
    tick(1);
    apb(1'b0, adr(`IDX_STATUS), 32'h0);
    check(32'(rd[7]), 32'h1);
    tick(14);
    apb(1'b0, adr(`IDX_STATUS), 32'h0);
    check({30'h0, rd[6:5]}, 32'h0);
    apb(1'b0, adr(`IDX_EVENTS), 32'h0);
    check(32'(rd[13]), 32'h1);
    // external mac wins before its slow transfer starts
    slow <= 1'b1;
    req[1] <= 1'b1;
    tick(4);
    offer(2'd3, 5'h1f);
    tick(2);
    apb(1'b0, adr(`IDX_STATUS), 32'h0);
    check(rd, exp_st(1, 0, 0, 0, 2'd3, 5'h1f));
    apb(1'b0, adr(`IDX_EVENTS), 32'h0);
    check({30'h0, rd[15:14]}, 32'h2);
    check(32'(rd[5]), 32'h1);
    req[1] <= 1'b0;
    tick(16);
    slow <= 1'b0;
    // programming mode blocks decisions; a running one ends only when its request drops
    apb(1'b1, adr(`IDX_CONTROL), 32'h1);
    req[0] <= 1'b1;
    tick(4);
    offer(2'd1, 5'h2);
    tick(2);
    apb(1'b0, adr(`IDX_STATUS), 32'h0);
    check({30'h0, rd[6:5]}, 32'h0);
    apb(1'b1, adr(`IDX_CONTROL), 32'h0);
    offer(2'd1, 5'h2);
    tick(2);
    apb(1'b0, adr(`IDX_EVENTS), 32'h0);
    check(32'(rd[15]), 32'h1);
    apb(1'b1, adr(`IDX_CONTROL), 32'h1);
    req[0] <= 1'b0;
    tick(16);
    apb(1'b0, adr(`IDX_STATUS), 32'h0);
    check({30'h0, rd[6:5]}, 32'h0);
    apb(1'b1, adr(`IDX_CONTROL), 32'h0);
    apb(1'b0, adr(`IDX_EVENTS), 32'h0);
    // random masks against random activity edges
    for (int k = 0; k < 8; k++)
    begin
      seed = xs(seed);
      m = {seed[15:1], (k % 2 == 0)};
      apb(1'b1, adr(`IDX_MASK), {16'h0, m});
      req <= req ^ seed[17:16];
      tick(16);
      sirq = irq;
      apb(1'b0, adr(`IDX_EVENTS), 32'h0);
      e = |(rd[15:0] & m & `EV_IMPL);
      check(32'(rd[0]), 32'(e));
      check(32'(sirq), 32'(e & m[0]));
      tick(2);
      check(32'(irq), 32'h0);
    end
    give_verdict;
  end
endmodule // radio_coex_status_irq_test
